// ===== logic/fur_pkg.sv
// shared constants and types for the flash unlock and address slice
package fur_pkg;
    // register byte offsets
    localparam logic [3:0] FUR_OFS_KEY  = 4'h0;
    localparam logic [3:0] FUR_OFS_ADDR = 4'h4;
    localparam logic [3:0] FUR_OFS_CTRL = 4'h8;
    localparam logic [3:0] FUR_OFS_STAT = 4'hc;
    // reset and zero values, full byte-enable mask
    localparam logic [31:0] FUR_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] FUR_ZERO     = 32'h0000_0000;
    localparam logic [3:0]  FUR_BE_ALL   = 4'hf;
    // control register fields
    localparam int FUR_CTRL_START = 4;
    localparam int FUR_CTRL_CLR   = 5;
    // status register fields
    localparam int FUR_STAT_BUSY = 0;
    localparam int FUR_STAT_OPEN = 1;
    localparam int FUR_STAT_ERR  = 2;
    localparam int FUR_STAT_DONE = 3;
    // operation kinds
    typedef enum logic [1:0] {
        FUR_OP_BULK = 2'h0,
        FUR_OP_PAGE = 2'h1,
        FUR_OP_ROW  = 2'h2,
        FUR_OP_WORD = 2'h3
    } fur_op_t;
    // command handed to the flash array
    typedef struct packed {
        fur_op_t     op;
        logic [31:0] addr;
    } fur_cmd_t;
    // unlock sequence states, gray along the path
    typedef enum logic [1:0] {
        FUR_UL_IDLE = 2'b00,
        FUR_UL_KEY1 = 2'b01,
        FUR_UL_OPEN = 2'b11
    } fur_ul_t;
    // avalon request bundle
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } fur_avs_req_t;
endpackage

// ===== logic/fur_unlock.sv
// unlock key sequence tracker
`timescale 1ns/1ps
module fur_unlock #(
    parameter logic [31:0] KEY_FIRST  = 32'h1234_5678, // arbitrary value
    parameter logic [31:0] KEY_SECOND = 32'h8765_4321  // arbitrary value
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // key write and consume strobes
    input  wire logic        key_wr_i,
    input  wire logic [31:0] key_data_i,
    input  wire logic        consume_i,
    // sequence complete
    output logic             open_o
);
    import fur_pkg::*;

    typedef struct packed {
        fur_ul_t st;
    } fur_ul_state_t;

    fur_ul_state_t s_r;
    fur_ul_state_t s_nxt;

    // advance on matching key writes, fall back on any other key write or on consume, hold otherwise
    always_comb
    begin
        s_nxt = s_r;
        if (consume_i)
            s_nxt.st = FUR_UL_IDLE;
        else if (key_wr_i)
        begin
            unique case (s_r.st)
                FUR_UL_IDLE:
                    s_nxt.st = (key_data_i == KEY_FIRST) ? FUR_UL_KEY1
                                                         : FUR_UL_IDLE;
                FUR_UL_KEY1:
                    s_nxt.st = (key_data_i == KEY_SECOND) ? FUR_UL_OPEN
                                                          : FUR_UL_IDLE;
                FUR_UL_OPEN:
                    s_nxt.st = FUR_UL_IDLE;
                default:
                    s_nxt.st = FUR_UL_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            s_r <= '{st: FUR_UL_IDLE};
        else
            s_r <= s_nxt;
    end

    assign open_o = (s_r.st == FUR_UL_OPEN);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_open_needs_second: assert property (
        $rose(open_o) |-> $past(key_wr_i && key_data_i == KEY_SECOND))
        else $error("unlock opened without second key");
    a_consume_closes: assert property (
        consume_i |=> !open_o)
        else $error("unlock not closed after use");
endmodule

// ===== logic/fur_top.sv
// flash unlock key and target address registers with op launch
// Behaviour
// - key register is write only and always reads as zero
// - flash changes start only after a completed key sequence
// - target address register is read-write and clears at reset
// - whole-memory erase ignores the target address
// - page erase acts on the page the target address selects
// - row program acts on the row the target address selects
// - word program acts on the word at the target address
`timescale 1ns/1ps
module fur_top
    import fur_pkg::*;
#(
    parameter int          PAGE_BYTES = 1024,
    parameter int          ROW_BYTES  = 128,
    parameter int          WORD_BYTES = 4,
    parameter logic [31:0] KEY_FIRST  = 32'h1234_5678, // arbitrary value
    parameter logic [31:0] KEY_SECOND = 32'h8765_4321  // arbitrary value
) (
    // clock and reset
    input  wire logic          CORE_CLK_I,
    input  wire logic          RST_N_I,
    // avalon-mm slave
    input  wire logic          AVS_READ_I,
    input  wire logic          AVS_WRITE_I,
    input  wire logic [3:0]    AVS_ADDRESS_I,
    input  wire logic [3:0]    AVS_BYTEENABLE_I,
    input  wire logic [31:0]   AVS_WRITEDATA_I,
    output logic [31:0]        AVS_READDATA_O,
    output logic               AVS_WAITREQUEST_O,
    // flash array command
    output logic               FLASH_START_O,
    output fur_pkg::fur_cmd_t  FLASH_CMD_O,
    input  wire logic          FLASH_DONE_I
);
    import fur_pkg::*;

    typedef struct packed {
        logic        wait_req;
        logic [31:0] rdata;
        logic [31:0] addr;
        fur_op_t     op_sel;
        logic        busy;
        logic        err;
        logic        done;
        logic        start;
        fur_cmd_t    cmd;
    } fur_state_t;

    fur_state_t   s_r;
    fur_state_t   s_nxt;
    fur_avs_req_t req;
    logic         ul_open;
    logic         key_wr;
    logic         commit;
    logic         ctrl_wr;
    logic         launch;

    // round an address down to a power-of-two unit
    function automatic logic [31:0] align(input logic [31:0] a,
                                          input int          unit);
        logic [31:0] m;
        m = 32'(unit) - 32'h0000_0001;
        return a & ~m;
    endfunction

    // merge write data into a word by byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // bus request bundle and accept-phase strobes
    assign req     = '{read: AVS_READ_I, write: AVS_WRITE_I,
                       address: AVS_ADDRESS_I,
                       byteenable: AVS_BYTEENABLE_I,
                       writedata: AVS_WRITEDATA_I};
    assign commit  = req.write && !s_r.wait_req;
    assign key_wr  = commit && req.address == FUR_OFS_KEY
                     && req.byteenable == FUR_BE_ALL;
    assign ctrl_wr = commit && req.address == FUR_OFS_CTRL
                     && req.byteenable[0];
    assign launch  = ctrl_wr && req.writedata[FUR_CTRL_START]
                     && ul_open && !s_r.busy;

    // key sequence tracker, consumed by any start attempt
    fur_unlock #(
        .KEY_FIRST  (KEY_FIRST),
        .KEY_SECOND (KEY_SECOND)
    ) u_unlock (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RST_N_I),
        .key_wr_i   (key_wr),
        .key_data_i (req.writedata),
        .consume_i  (ctrl_wr && req.writedata[FUR_CTRL_START]),
        .open_o     (ul_open)
    );

    // bus handshake, registers and operation launch
    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.start = 1'b0;
        // one wait cycle, then accept
        if ((req.read || req.write) && s_r.wait_req)
        begin
            s_nxt.wait_req = 1'b0;
            unique case (req.address)
                FUR_OFS_KEY:  s_nxt.rdata = FUR_ZERO;
                FUR_OFS_ADDR: s_nxt.rdata = s_r.addr;
                FUR_OFS_CTRL: s_nxt.rdata = {30'h0000_0000, s_r.op_sel};
                FUR_OFS_STAT:
                begin
                    s_nxt.rdata                = FUR_ZERO;
                    s_nxt.rdata[FUR_STAT_BUSY] = s_r.busy;
                    s_nxt.rdata[FUR_STAT_OPEN] = ul_open;
                    s_nxt.rdata[FUR_STAT_ERR]  = s_r.err;
                    s_nxt.rdata[FUR_STAT_DONE] = s_r.done;
                end
                default:      s_nxt.rdata = FUR_ZERO;
            endcase
        end
        else
            s_nxt.wait_req = 1'b1;
        // target address write
        if (commit && req.address == FUR_OFS_ADDR)
            s_nxt.addr = merge(s_r.addr, req.writedata,
                               req.byteenable);
        // control write: select op, clear flags, try to start
        if (ctrl_wr)
        begin
            s_nxt.op_sel = fur_op_t'(req.writedata[1:0]);
            if (req.writedata[FUR_CTRL_CLR])
            begin
                s_nxt.err  = 1'b0;
                s_nxt.done = 1'b0;
            end
            if (req.writedata[FUR_CTRL_START] && !launch)
                s_nxt.err = 1'b1;
        end
        if (launch)
        begin
            s_nxt.busy    = 1'b1;
            s_nxt.start   = 1'b1;
            s_nxt.done    = 1'b0;
            s_nxt.cmd.op  = fur_op_t'(req.writedata[1:0]);
            unique case (fur_op_t'(req.writedata[1:0]))
                FUR_OP_BULK: s_nxt.cmd.addr = FUR_ZERO;
                FUR_OP_PAGE:
                    s_nxt.cmd.addr = align(s_r.addr, PAGE_BYTES);
                FUR_OP_ROW:
                    s_nxt.cmd.addr = align(s_r.addr, ROW_BYTES);
                FUR_OP_WORD:
                    s_nxt.cmd.addr = align(s_r.addr, WORD_BYTES);
            endcase
        end
        // completion from the array, set wins over clear
        if (s_r.busy && FLASH_DONE_I)
        begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
        end
    end

    // state register
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            s_r          <= '0;
            s_r.wait_req <= 1'b1;
            s_r.addr     <= FUR_ADDR_RST;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from flops
    assign AVS_READDATA_O    = s_r.rdata;
    assign AVS_WAITREQUEST_O = s_r.wait_req;
    assign FLASH_START_O     = s_r.start;
    assign FLASH_CMD_O       = s_r.cmd;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_launch(fur_op_t k);
        launch && fur_op_t'(req.writedata[1:0]) == k;
    endsequence

    a_key_reads_zero: assert property (
        (AVS_READ_I && s_r.wait_req && AVS_ADDRESS_I == FUR_OFS_KEY)
        |=> !AVS_WAITREQUEST_O && AVS_READDATA_O == FUR_ZERO)
        else $error("key register read not zero");
    a_start_needs_key: assert property (
        $rose(FLASH_START_O) |-> $past(ul_open))
        else $error("flash started without unlock");
    a_locked_start_err: assert property (
        (ctrl_wr && req.writedata[FUR_CTRL_START] && !ul_open)
        |=> !FLASH_START_O && s_r.err)
        else $error("locked start not refused");
    a_addr_reset_zero: assert property (
        $past(!RST_N_I) |-> s_r.addr == FUR_ADDR_RST)
        else $error("target address not cleared");
    a_addr_write_held: assert property (
        (commit && AVS_ADDRESS_I == FUR_OFS_ADDR
         && AVS_BYTEENABLE_I == FUR_BE_ALL)
        |=> s_r.addr == $past(AVS_WRITEDATA_I))
        else $error("target address write lost");
    a_bulk_addr_ignored: assert property (
        s_launch(FUR_OP_BULK) |=> FLASH_START_O
        && FLASH_CMD_O.addr == FUR_ZERO)
        else $error("bulk erase used the address");
    a_page_addr_used: assert property (
        s_launch(FUR_OP_PAGE) |=> FLASH_START_O
        && FLASH_CMD_O.addr == align($past(s_r.addr), PAGE_BYTES))
        else $error("page erase address wrong");
    a_row_addr_used: assert property (
        s_launch(FUR_OP_ROW) |=> FLASH_START_O
        && FLASH_CMD_O.addr == align($past(s_r.addr), ROW_BYTES))
        else $error("row program address wrong");
    a_word_addr_used: assert property (
        s_launch(FUR_OP_WORD) |=> FLASH_START_O
        && FLASH_CMD_O.addr == align($past(s_r.addr), WORD_BYTES)
        ##1 !FLASH_START_O)
        else $error("word program address wrong");
endmodule

// ===== sim/testbench.sv
// self-checking bench for the flash unlock and address slice
`timescale 1ns/1ps
module testbench;
    import fur_pkg::*;
    localparam logic [31:0] K1 = 32'h0f1e_2d3c; // arbitrary value
    localparam logic [31:0] K2 = 32'hc3d2_e1f0; // arbitrary value
    localparam logic [31:0] A  = 32'h1234_5abe;
    localparam int          PG = 1024;
    localparam int          RW = 128;
    localparam int          WD = 4;
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic        rd       = 1'b0;
    logic        wr       = 1'b0;
    logic [3:0]  adr      = 4'h0;
    logic [3:0]  be       = 4'h0;
    logic [31:0] wdat     = 32'h0;
    logic        done     = 1'b0;
    logic [31:0] rdat;
    logic        wait_q;
    logic        start;
    fur_cmd_t    cmd;
    fur_cmd_t    last_cmd;
    int          n_starts = 0;
    int          n_errors = 0;
    int          checks   = 0;
    logic [31:0] v;

    fur_top #(.PAGE_BYTES(PG), .ROW_BYTES(RW), .WORD_BYTES(WD),
              .KEY_FIRST(K1), .KEY_SECOND(K2)) i_dut (
        .CORE_CLK_I        (clk),
        .RST_N_I           (rst_n),
        .AVS_READ_I        (rd),
        .AVS_WRITE_I       (wr),
        .AVS_ADDRESS_I     (adr),
        .AVS_BYTEENABLE_I  (be),
        .AVS_WRITEDATA_I   (wdat),
        .AVS_READDATA_O    (rdat),
        .AVS_WAITREQUEST_O (wait_q),
        .FLASH_START_O     (start),
        .FLASH_CMD_O       (cmd),
        .FLASH_DONE_I      (done)
    );

    // 10 MHz core clock
    initial
    begin
        forever #50 clk = ~clk;
    end

    // record every launch seen on the flash link
    always @(posedge clk)
    begin
        if (start === 1'b1)
        begin
            n_starts <= n_starts + 1;
            last_cmd <= cmd;
        end
    end

    // verdict and end of run
    task automatic end_sim();
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // compare one value
    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        rd   <= ~w;
        wr   <= w;
        adr  <= a;
        wdat <= d;
        be   <= b;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_q !== 1'b0 && n < 50);
        q = rdat;
        if (n >= 50)
            n_errors++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr32(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask

    task automatic rd32(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, FUR_BE_ALL, q);
    endtask

    // start attempt that must be turned away
    task automatic refuse();
        int          s;
        logic [31:0] q;
        s = n_starts;
        wr32(FUR_OFS_CTRL, 32'h10 | 32'(FUR_OP_PAGE), FUR_BE_ALL);
        repeat (3) @(posedge clk);
        chk32("no_start", 32'(s), 32'(n_starts));
        rd32(FUR_OFS_STAT, q);
        chk32("err", 32'h1, 32'(q[FUR_STAT_ERR]));
        wr32(FUR_OFS_CTRL, 32'h20, FUR_BE_ALL);
    endtask

    // unlock, launch one operation, finish it; caller checks the command
    task automatic launch(input fur_op_t op);
        int          s;
        logic [31:0] q;
        s = n_starts;
        wr32(FUR_OFS_KEY, K1, FUR_BE_ALL);
        wr32(FUR_OFS_KEY, K2, FUR_BE_ALL);
        rd32(FUR_OFS_STAT, q);
        chk32("open", 32'h1, 32'(q[FUR_STAT_OPEN]));
        wr32(FUR_OFS_ADDR, A, FUR_BE_ALL);
        wr32(FUR_OFS_CTRL, 32'h10 | 32'(op), FUR_BE_ALL);
        repeat (3) @(posedge clk);
        chk32("starts", 32'(s + 1), 32'(n_starts));
        rd32(FUR_OFS_CTRL, q);
        chk32("ctrl_op", 32'(op), q);
        rd32(FUR_OFS_STAT, q);
        chk32("busy", 32'h1, 32'(q[FUR_STAT_BUSY]));
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        rd32(FUR_OFS_STAT, q);
        chk32("done", 32'h1, 32'(q[FUR_STAT_DONE]));
        chk32("idle", 32'h0, 32'(q[FUR_STAT_BUSY]));
        wr32(FUR_OFS_CTRL, 32'h20, FUR_BE_ALL);
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd32(FUR_OFS_ADDR, v);
        chk32("addr_rst", FUR_ADDR_RST, v);
        rd32(FUR_OFS_KEY, v);
        chk32("key_rst", FUR_ZERO, v);
        wr32(FUR_OFS_ADDR, A, FUR_BE_ALL);
        rd32(FUR_OFS_ADDR, v);
        chk32("addr_rw", A, v);
        wr32(FUR_OFS_ADDR, 32'hffff_ffff, 4'h3);
        rd32(FUR_OFS_ADDR, v);
        chk32("addr_be", {A[31:16], 16'hffff}, v);
        wr32(FUR_OFS_ADDR, A, FUR_BE_ALL);
        wr32(4'h6, 32'h0, FUR_BE_ALL);
        rd32(FUR_OFS_ADDR, v);
        chk32("addr_unm", A, v);
        rd32(4'h2, v);
        chk32("unmapped", FUR_ZERO, v);
        wr32(FUR_OFS_KEY, K1, FUR_BE_ALL);
        rd32(FUR_OFS_KEY, v);
        chk32("key_rd", FUR_ZERO, v);
        refuse();
        // broken key sequence: wrong middle key
        wr32(FUR_OFS_KEY, K1, FUR_BE_ALL);
        wr32(FUR_OFS_KEY, 32'h0, FUR_BE_ALL);
        wr32(FUR_OFS_KEY, K2, FUR_BE_ALL);
        refuse();
        // second key with a missing byte lane does not count
        wr32(FUR_OFS_KEY, K1, FUR_BE_ALL);
        wr32(FUR_OFS_KEY, K2, 4'h7);
        refuse();
        // whole-memory erase sends address zero whatever is held
        launch(FUR_OP_BULK);
        chk32("bulk_op", 32'(FUR_OP_BULK), 32'(last_cmd.op));
        chk32("bulk_addr", 32'h0000_0000, last_cmd.addr);
        // held address 1234_5abe down to a 1024-byte page
        launch(FUR_OP_PAGE);
        chk32("page_op", 32'(FUR_OP_PAGE), 32'(last_cmd.op));
        chk32("page_addr", 32'h1234_5800, last_cmd.addr);
        // down to a 128-byte row
        launch(FUR_OP_ROW);
        chk32("row_op", 32'(FUR_OP_ROW), 32'(last_cmd.op));
        chk32("row_addr", 32'h1234_5a80, last_cmd.addr);
        // down to a 4-byte word
        launch(FUR_OP_WORD);
        chk32("word_op", 32'(FUR_OP_WORD), 32'(last_cmd.op));
        chk32("word_addr", 32'h1234_5abc, last_cmd.addr);
        refuse();
        // reset in mid-run drops an open unlock
        wr32(FUR_OFS_KEY, K1, FUR_BE_ALL);
        wr32(FUR_OFS_KEY, K2, FUR_BE_ALL);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd32(FUR_OFS_ADDR, v);
        chk32("addr_rst2", FUR_ADDR_RST, v);
        refuse();
        end_sim();
    end

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule
